// *** design/etp_ch_if.sv ***
// signals between the timer core and one output / capture channel
`default_nettype none

interface etp_ch_if
  import etp_pkg::*;
();
  etp_op_t op;          // decoded operating mode
  logic [1:0] ctl;      // output control / capture edge code
  logic init;           // initial state, selects active level
  logic pol;            // inverts the shaped waveform
  logic wave;           // raw active phase from the core
  logic allow;          // pin may be driven as an output
  logic pin_in;         // sampled pin level
  logic cap_evt;        // capture strobe back to the core
  logic pin_out;        // pin drive level
  logic pin_oe;         // pin drive enable

  modport core (
    output op, ctl, init, pol, wave, allow, pin_in,
    input cap_evt, pin_out, pin_oe
  );
  modport chan (
    input op, ctl, init, pol, wave, allow, pin_in,
    output cap_evt, pin_out, pin_oe
  );
endinterface : etp_ch_if

`default_nettype wire

// *** design/etp_channel.sv ***
// one channel: capture edge detector and output pin shaping
`default_nettype none

module etp_channel
  import etp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // link to the core
  etp_ch_if.chan ch
);

  // ****************************************
  // capture edge detection
  // ****************************************
  logic pin_prev_reg;   // pin level one cycle ago
  logic hit;            // selected edge seen
  logic lvl;            // shaped waveform level

  // pin is synchronous already, so one stage is enough for edges
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pin_prev_reg <= 1'b0;
    else
      pin_prev_reg <= ch.pin_in;
  end

  always_comb
  begin
    hit = 1'b0;
    unique case (etp_edge_t'(ch.ctl))
      EDGE_RISE: hit = ch.pin_in & ~pin_prev_reg;
      EDGE_FALL: hit = ~ch.pin_in & pin_prev_reg;
      EDGE_BOTH: hit = ch.pin_in ^ pin_prev_reg;
      EDGE_OFF: hit = 1'b0;
    endcase
  end

  assign ch.cap_evt = (ch.op == OP_CAP) & hit;

  // ****************************************
  // output shaping
  // ****************************************
  // init picks level, pol inverts
  assign lvl = (ch.wave ? ch.init : ~ch.init) ^ ch.pol;

  // registered so the pin never glitches on compare decode
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ch.pin_out <= 1'b0;
      ch.pin_oe <= 1'b0;
    end
    else if ((ch.op == OP_PWM || ch.op == OP_PULSE) && ch.allow)
    begin
      ch.pin_oe <= 1'b1;
      if (ch.ctl == CTL_LOW)
        ch.pin_out <= 1'b0;
      else if (ch.ctl == CTL_HIGH)
        ch.pin_out <= 1'b1;
      else
        ch.pin_out <= lvl;
    end
    else
    begin
      ch.pin_out <= 1'b0;
      ch.pin_oe <= 1'b0;
    end
  end

endmodule : etp_channel

`default_nettype wire

// *** design/etp_pkg.sv ***
// constants and types shared by the timer pwm / pulse / capture block
`default_nettype none

package etp_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int CNT_W = 10;        // counter and compare width
  localparam int CH_CFG_W = 6;      // channel config register width
  localparam int FLAG_W = 3;        // a, b, period flags

  // ****************************************
  // apb register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHA = 8'h04;
  localparam logic [7:0] ADDR_CHB = 8'h08;
  localparam logic [7:0] ADDR_CMPA = 8'h0C;
  localparam logic [7:0] ADDR_CMPB = 8'h10;
  localparam logic [7:0] ADDR_FLAG = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_RUN = 0;      // run_bit
  localparam int CTRL_CLR = 1;      // counter_clear_select
  localparam int CTRL_ALIGN = 2;    // alignment_select, 2 bits
  localparam int CTRL_PCODE = 4;    // period_code, 3 bits
  localparam int CTRL_PRESC = 8;    // timer clock prescale, 2 bits
  localparam int CH_MODE = 0;       // channel mode, 2 bits
  localparam int CH_CTL = 2;        // output control, 2 bits
  localparam int CH_INIT = 4;       // output initial state
  localparam int CH_POL = 5;        // output polarity
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_P = 2;

  // ****************************************
  // reset values and timing counts
  // ****************************************
  localparam logic [31:0] RD_RESET = 32'h0000_0000;
  localparam logic [5:0] PRESC_M1 = 6'h00;   // tick every cycle
  localparam logic [5:0] PRESC_M4 = 6'h03;
  localparam logic [5:0] PRESC_M16 = 6'h0F;
  localparam logic [5:0] PRESC_M64 = 6'h3F;
  localparam logic [6:0] STEP_LOW = 7'h7F;   // 128 counts per code step
  localparam logic [9:0] CENTRE_TOP_MAX = 10'h3FF;
  localparam logic [1:0] ALIGN_CENTRE = 2'h3;
  localparam logic [1:0] CTL_LOW = 2'h0;
  localparam logic [1:0] CTL_HIGH = 2'h1;
  localparam logic [1:0] CTL_PULSE = 2'h3;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TC = 2'b11
  } etp_mode_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_PWM = 2'b01,
    OP_PULSE = 2'b10,
    OP_CAP = 2'b11
  } etp_op_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_OFF = 2'b11
  } etp_edge_t;

endpackage : etp_pkg

`default_nettype wire

// *** design/etp_top.sv ***
// timer top: apb registers, counter, pwm, single pulse and capture
//
// The address map and the APB slave port were decided locally.
`default_nettype none

module etp_top
  import etp_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // external trigger
  input wire logic I_TRIG,
  // channel a pin
  input wire logic I_CHA_PIN,
  output logic O_CHA_PIN,
  output logic O_CHA_PIN_OE,
  // channel b pin
  input wire logic I_CHB_PIN,
  output logic O_CHB_PIN,
  output logic O_CHB_PIN_OE
);

  // ****************************************
  // state
  // ****************************************
  // ten bit counter and compares
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] cmp_reg [2];      // compare / capture a, b
  logic [CH_CFG_W-1:0] cfg_reg [2];   // channel config a, b
  logic down_reg, down_next;          // centre mode direction
  logic run_reg, run_next;            // run_bit
  logic clr_sel_reg;                  // counter_clear_select
  logic [1:0] align_reg;              // alignment_select
  logic [2:0] pcode_reg;              // period_code
  logic [1:0] presc_reg;              // timer clock prescale
  logic [FLAG_W-1:0] flag_reg;        // match and period flags
  logic pulse_b_reg;                  // output b pulse active
  logic trig_prev_reg;                // trigger level last cycle
  logic [5:0] div_reg;                // prescale divider
  logic [31:0] prdata_reg;            // read data register

  // ****************************************
  // decode
  // ****************************************
  etp_op_t op;                 // decoded operating mode
  logic [5:0] div_mask;        // prescale mask
  logic tick;                  // one-cycle timer clock enable
  logic cnt_en;                // counter advances this cycle
  logic run_rise;              // run bit about to rise
  logic centre;                // centre aligned pwm
  logic [CNT_W-1:0] per_m1;    // last count of an edge period
  logic [CNT_W-1:0] top;       // turn point of centre count
  logic wrap;                  // edge style wrap to zero
  logic zero_hit;              // centre down count reaches zero
  logic match_a, match_b;      // compare equal on a tick
  logic trig_edge;             // trigger rising edge
  logic wr_en, rd_setup;       // apb phases
  logic addr_ok;               // mapped address
  logic [31:0] rd_mux;         // read data before register
  logic [FLAG_W-1:0] flag_set; // hardware flag sets
  logic [1:0] cap_evt;         // capture strobes
  logic [1:0] wave;            // raw waveforms

  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_setup = I_PSEL & ~I_PENABLE;

  always_comb
  begin
    op = OP_IDLE;
    unique case (etp_mode_t'(cfg_reg[0][CH_MODE +: 2]))
      MODE_PWM:
        // both controls 11 gives single pulse
        if (cfg_reg[1][CH_MODE +: 2] == MODE_PWM)
          op = (cfg_reg[0][CH_CTL +: 2] == CTL_PULSE &&
                cfg_reg[1][CH_CTL +: 2] == CTL_PULSE) ?
               OP_PULSE : OP_PWM;
      MODE_CAP:
        if (cfg_reg[1][CH_MODE +: 2] == MODE_CAP)
          op = OP_CAP;
      MODE_CMP, MODE_TC: op = OP_IDLE;
    endcase
  end

  // prescale choice; the divider runs free so ticks stay regular
  always_comb
  begin
    unique case (presc_reg)
      2'b00: div_mask = PRESC_M1;
      2'b01: div_mask = PRESC_M4;
      2'b10: div_mask = PRESC_M16;
      2'b11: div_mask = PRESC_M64;
    endcase
  end

  assign tick = (div_reg & div_mask) == 6'h00;
  assign cnt_en = run_reg & tick;
  assign run_rise = run_next & ~run_reg;
  assign trig_edge = I_TRIG & ~trig_prev_reg;

  assign centre = (op == OP_PWM) && (align_reg == ALIGN_CENTRE);

  // code times 128, code zero wraps to 1024
  assign per_m1 = (op == OP_PWM && clr_sel_reg) ?
                  CNT_W'(cmp_reg[0] - 10'h001) :
                  {3'(pcode_reg - 3'h1), STEP_LOW};

  // centre top per code, zero gives 1023
  // clear-select high turns at compare a
  always_comb
  begin
    if (clr_sel_reg)
      top = (cmp_reg[0] == 10'h000) ? 10'h001 : cmp_reg[0];
    else if (pcode_reg == 3'h0)
      top = CENTRE_TOP_MAX;
    else
      top = {pcode_reg, 7'h00};
  end

  assign match_a = cnt_en & (cnt_reg == cmp_reg[0]);
  assign match_b = cnt_en & (cnt_reg == cmp_reg[1]);

  // ****************************************
  // counter
  // ****************************************
  always_comb
  begin
    cnt_next = cnt_reg;
    down_next = down_reg;
    wrap = 1'b0;
    zero_hit = 1'b0;
    if (run_rise)
    begin
      cnt_next = '0;
      down_next = 1'b0;
    end
    else if (cnt_en && centre)
    begin
      // up to top, then back down
      if (!down_reg)
      begin
        if (cnt_reg >= top)
        begin
          down_next = 1'b1;
          cnt_next = CNT_W'(cnt_reg - 10'h001);
        end
        else
          cnt_next = CNT_W'(cnt_reg + 10'h001);
      end
      else
      begin
        cnt_next = CNT_W'(cnt_reg - 10'h001);
        if (cnt_reg == 10'h001)
        begin
          down_next = 1'b0;
          zero_hit = 1'b1;
        end
      end
    end
    else if (cnt_en)
    begin
      if (op != OP_PULSE && cnt_reg == per_m1)
      begin
        // capture wraps at the period too
        cnt_next = '0;
        wrap = 1'b1;
      end
      else
        cnt_next = CNT_W'(cnt_reg + 10'h001);
    end
  end

  // counter and direction hold while run is low
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      cnt_reg <= '0;
      down_reg <= 1'b0;
      div_reg <= 6'h00;
    end
    else
    begin
      cnt_reg <= cnt_next;
      down_reg <= down_next;
      div_reg <= 6'(div_reg + 6'h01);
    end
  end

  // ****************************************
  // run bit
  // ****************************************
  // later lines win: the trigger set beats every clear
  always_comb
  begin
    run_next = run_reg;
    if (wr_en && I_PADDR == ADDR_CTRL)
      run_next = I_PWDATA[CTRL_RUN];
    if (op == OP_PULSE && match_a)
      run_next = 1'b0;
    if (op == OP_PULSE && trig_edge)
      run_next = 1'b1;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      run_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      pulse_b_reg <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      trig_prev_reg <= I_TRIG;
      // run low ends output b too
      if (!run_next)
        pulse_b_reg <= 1'b0;
      else if (op == OP_PULSE && match_b)
        pulse_b_reg <= 1'b1;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  always_comb
  begin
    flag_set = '0;
    unique case (op)
      OP_PWM:
      begin
        // clear-select high, edge aligned: a match is the wrap
        flag_set[FLAG_A] = (clr_sel_reg && !centre) ? wrap : match_a;
        flag_set[FLAG_B] = match_b;
        flag_set[FLAG_P] = centre ? zero_hit : (wrap & ~clr_sel_reg);
      end
      OP_PULSE:
      begin
        flag_set[FLAG_A] = match_a;
        flag_set[FLAG_B] = match_b;
      end
      OP_CAP:
      begin
        flag_set[FLAG_A] = cap_evt[0];
        flag_set[FLAG_B] = cap_evt[1];
        flag_set[FLAG_P] = wrap;
      end
      OP_IDLE: flag_set = '0;
    endcase
  end

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      flag_reg <= '0;
    else if (wr_en && I_PADDR == ADDR_FLAG)
      flag_reg <= (flag_reg & ~I_PWDATA[FLAG_W-1:0]) | flag_set;
    else
      flag_reg <= flag_reg | flag_set;
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      clr_sel_reg <= 1'b0;
      align_reg <= 2'b00;
      pcode_reg <= 3'h0;
      presc_reg <= 2'b00;
    end
    else if (wr_en && I_PADDR == ADDR_CTRL)
    begin
      clr_sel_reg <= I_PWDATA[CTRL_CLR];
      align_reg <= I_PWDATA[CTRL_ALIGN +: 2];
      pcode_reg <= I_PWDATA[CTRL_PCODE +: 3];
      presc_reg <= I_PWDATA[CTRL_PRESC +: 2];
    end
  end

  // ****************************************
  // channels
  // ****************************************
  etp_ch_if ch_if [2] ();

  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    logic full;   // duty reaches the period

    // channel config, written by software only
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
      if (!I_RST_B)
        cfg_reg[i] <= '0;
      else if (wr_en && I_PADDR == (i == 0 ? ADDR_CHA : ADDR_CHB))
        cfg_reg[i] <= I_PWDATA[CH_CFG_W-1:0];
    end

    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
      if (!I_RST_B)
        cmp_reg[i] <= '0;
      else if (cap_evt[i])
        cmp_reg[i] <= cnt_reg;
      else if (wr_en && I_PADDR == (i == 0 ? ADDR_CMPA : ADDR_CMPB))
        cmp_reg[i] <= I_PWDATA[CNT_W-1:0];
    end

    // duty at or past period stays active
    assign full = centre ? (cmp_reg[i] > top) : (cmp_reg[i] > per_m1);

    // all edge waves start at count zero
    // output a follows run in pulse mode
    assign wave[i] = (op == OP_PULSE) ?
                     (i == 0 ? run_reg : pulse_b_reg) :
                     (full | (cnt_reg < cmp_reg[i]));

    assign ch_if[i].op = op;
    assign ch_if[i].ctl = cfg_reg[i][CH_CTL +: 2];
    assign ch_if[i].init = cfg_reg[i][CH_INIT];
    assign ch_if[i].pol = cfg_reg[i][CH_POL];
    assign ch_if[i].wave = wave[i];
    // pin a not driven in pwm mode with clear-select high
    assign ch_if[i].allow = (i != 0) || !(op == OP_PWM && clr_sel_reg);
    assign cap_evt[i] = ch_if[i].cap_evt;

    etp_channel u_ch (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .ch(ch_if[i])
    );
  end

  assign ch_if[0].pin_in = I_CHA_PIN;
  assign ch_if[1].pin_in = I_CHB_PIN;
  assign O_CHA_PIN = ch_if[0].pin_out;
  assign O_CHA_PIN_OE = ch_if[0].pin_oe;
  assign O_CHB_PIN = ch_if[1].pin_out;
  assign O_CHB_PIN_OE = ch_if[1].pin_oe;

  // ****************************************
  // apb read path
  // ****************************************
  // read data is taken in the setup cycle so it leaves a flop
  always_comb
  begin
    rd_mux = RD_RESET;
    addr_ok = 1'b1;
    unique case (I_PADDR)
      ADDR_CTRL:
      begin
        rd_mux[CTRL_RUN] = run_reg;
        rd_mux[CTRL_CLR] = clr_sel_reg;
        rd_mux[CTRL_ALIGN +: 2] = align_reg;
        rd_mux[CTRL_PCODE +: 3] = pcode_reg;
        rd_mux[CTRL_PRESC +: 2] = presc_reg;
      end
      ADDR_CHA: rd_mux[CH_CFG_W-1:0] = cfg_reg[0];
      ADDR_CHB: rd_mux[CH_CFG_W-1:0] = cfg_reg[1];
      ADDR_CMPA: rd_mux[CNT_W-1:0] = cmp_reg[0];
      ADDR_CMPB: rd_mux[CNT_W-1:0] = cmp_reg[1];
      ADDR_FLAG: rd_mux[FLAG_W-1:0] = flag_reg;
      ADDR_COUNT: rd_mux[CNT_W-1:0] = cnt_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      prdata_reg <= RD_RESET;
    else if (rd_setup)
      prdata_reg <= rd_mux;
  end

  // zero wait states; unmapped addresses answer with an error
  assign O_PRDATA = prdata_reg;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_edge_wrap;
    op == OP_PWM && !centre && !clr_sel_reg && cnt_en && !run_rise &&
    cnt_reg == per_m1;
  endsequence
  sequence s_pulse_a_hit;
    op == OP_PULSE && match_a && !trig_edge && !run_rise;
  endsequence

  edge_period_a:
    assert property (s_edge_wrap |=> cnt_reg == 10'h000 && flag_reg[FLAG_P])
    else $error("edge period wrap wrong");

  full_duty_a:
    assert property (op == OP_PWM && !centre && !clr_sel_reg &&
      cmp_reg[0] > per_m1 && cfg_reg[0][CH_CTL +: 2] == 2'b10 &&
      cfg_reg[0][CH_INIT] && !cfg_reg[0][CH_POL] |=> O_CHA_PIN)
    else $error("full duty not held");

  pwm_runs_a:
    assert property (op == OP_PWM && !centre &&
      cfg_reg[0][CH_CTL +: 2] == CTL_LOW && cnt_en && !run_rise &&
      cnt_reg != per_m1 |=> cnt_reg == 10'($past(cnt_reg) + 10'h001))
    else $error("pwm counter stalled");

  pulse_start_a:
    assert property (op == OP_PULSE && $rose(run_reg) |-> cnt_reg == 10'h000)
    else $error("pulse start not from zero");

  trig_run_a:
    assert property (op == OP_PULSE && trig_edge |=> run_reg)
    else $error("trigger did not set run");

  // pin a must sit at its idle level, the inverse of init xor pol, after the end
  pulse_end_a:
    assert property (s_pulse_a_hit |=> !run_reg ##1 (!O_CHA_PIN_OE ||
      O_CHA_PIN == (cfg_reg[0][CH_INIT] ~^ cfg_reg[0][CH_POL])))
    else $error("pulse not ended by compare a");

  pulse_b_a:
    assert property (op == OP_PULSE && match_b && run_next |=> pulse_b_reg)
    else $error("output b pulse not started");

  centre_zero_a:
    assert property (centre && cnt_en && down_reg && cnt_reg == 10'h001 &&
      !run_rise |=> cnt_reg == 10'h000 && !down_reg && flag_reg[FLAG_P])
    else $error("centre zero flag missing");

  cap_latch_a:
    assert property (cap_evt[0] |=> cmp_reg[0] == $past(cnt_reg) &&
      flag_reg[FLAG_A])
    else $error("capture did not latch");

  cap_off_a:
    assert property (op == OP_CAP && cfg_reg[1][CH_CTL +: 2] == CTL_PULSE
      |-> !cap_evt[1])
    else $error("capture while disabled");

endmodule : etp_top

`default_nettype wire

// *** dv/etp_pins_model.sv ***
// pin-side partner: trigger and capture pin drivers
`default_nettype none

module etp_pins_model
(
  // clock and command from the bench
  input wire logic i_clk,
  input wire logic i_fire,
  // pins toward the timer
  output logic o_trig,
  output logic o_pin_a,
  output logic o_pin_b
);
  timeunit 1ns;
  timeprecision 1ns;

  // pins idle low so no stray edge appears at start
  initial {o_trig, o_pin_a, o_pin_b} = 3'b000;

  // one clean rising edge per fire
  always @(posedge i_clk)
  begin
    o_trig <= i_fire;
    o_pin_a <= i_fire;
    o_pin_b <= i_fire;
  end
endmodule : etp_pins_model

`default_nettype wire

// *** dv/etp_top_tb_top.sv ***
// self-checking bench for the timer pwm / capture block
`default_nettype none

module etp_top_tb_top
  import etp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, psel, pen, pwr, fire, trig, pa, pb;
  logic [7:0] addr;
  logic [31:0] wd, prd, rd;
  logic rdy, err, er, oa, oa_oe, ob, ob_oe;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;

  etp_top uut (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd),
    .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .I_TRIG(trig),
    .I_CHA_PIN(pa), .O_CHA_PIN(oa), .O_CHA_PIN_OE(oa_oe),
    .I_CHB_PIN(pb), .O_CHB_PIN(ob), .O_CHB_PIN_OE(ob_oe));
  etp_pins_model pins (.i_clk(clk), .i_fire(fire), .o_trig(trig),
    .o_pin_a(pa), .o_pin_b(pb));

  // clock at 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // a hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // reset values and an unmapped place
  task automatic reg_test();
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk("ctrl", RD_RESET, rd);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, er});
  endtask : reg_test

  // driven-high cycles of both pins over n cycles; sampled mid-cycle
  // because the pin flops change on the rising edge
  task automatic count_hi(input int n, output int ha, output int hb,
                          output int hoe);
    ha = 0;
    hb = 0;
    hoe = 0;
    repeat (n)
    begin
      @(negedge clk);
      ha += (oa === 1'b1 && oa_oe === 1'b1);
      hb += (ob === 1'b1 && ob_oe === 1'b1);
      hoe += (oa_oe === 1'b1);
    end
  endtask : count_hi

  // edge pwm, code 1: period 128, duty a 32, duty b above period
  task automatic pwm_test();
    int ha;
    int hb;
    int hoe;
    apb(1'b1, ADDR_CHA, 32'h0000_001A);
    apb(1'b1, ADDR_CHB, 32'h0000_001A);
    apb(1'b1, ADDR_CMPA, 32'h0000_0020);
    apb(1'b1, ADDR_CMPB, 32'h0000_00C8);
    apb(1'b1, ADDR_CTRL, 32'h0000_0011);
    repeat (200) @(posedge clk);
    count_hi(128, ha, hb, hoe);
    chk("pin_a_high", 32, ha);
    chk("pin_b_high", 128, hb);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
  endtask : pwm_test

  // capture on a rise at pin a; pin b disabled by code 11
  task automatic cap_test();
    apb(1'b1, ADDR_CHA, 32'h0000_0001);
    apb(1'b1, ADDR_CHB, 32'h0000_000D);
    apb(1'b1, ADDR_FLAG, 32'h0000_0007);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clk);
    fire <= 1'b1;
    repeat (5) @(posedge clk);
    fire <= 1'b0;
    apb(1'b0, ADDR_FLAG, 32'h0000_0000);
    chk("cap_flags", 32'h0000_0001, rd);
    apb(1'b0, ADDR_CMPA, 32'h0000_0000);
    // count is 0 at the run edge; the pin model flop adds one, edge detect none
    chk("cap_value", 32'h0000_0015, rd);
  endtask : cap_test

  // centre pwm, code 1: period 256, duty 2c-1; then period from cmp a
  task automatic centre_test();
    int ha;
    int hb;
    int hoe;
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CHA, 32'h0000_001A);
    apb(1'b1, ADDR_CHB, 32'h0000_001A);
    apb(1'b1, ADDR_CMPA, 32'h0000_0004);
    apb(1'b1, ADDR_CMPB, 32'h0000_0040);
    apb(1'b1, ADDR_FLAG, 32'h0000_0007);
    apb(1'b1, ADDR_CTRL, 32'h0000_001D);
    repeat (40) @(posedge clk);
    count_hi(256, ha, hb, hoe);
    chk("centre_a_high", 7, ha);
    chk("centre_b_high", 127, hb);
    apb(1'b0, ADDR_FLAG, 32'h0000_0000);
    chk("centre_flags", 32'h0000_0007, rd);
    // clear-select high: period 8 from cmp a 4, b duty 3
    apb(1'b1, ADDR_CMPB, 32'h0000_0002);
    apb(1'b1, ADDR_CTRL, 32'h0000_000F);
    repeat (150) @(posedge clk);
    count_hi(64, ha, hb, hoe);
    chk("clr_b_high", 24, hb);
    chk("clr_a_oe", 0, hoe);
  endtask : centre_test

  // single pulse launched by the trigger pin, cmp a 32, cmp b 16
  task automatic pulse_test();
    int ha;
    int hb;
    int hoe;
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_CHA, 32'h0000_001E);
    apb(1'b1, ADDR_CHB, 32'h0000_001E);
    apb(1'b1, ADDR_CMPA, 32'h0000_0020);
    apb(1'b1, ADDR_CMPB, 32'h0000_0010);
    apb(1'b1, ADDR_FLAG, 32'h0000_0007);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    count_hi(60, ha, hb, hoe);
    // a stays up while the count runs 0 through cmp a
    chk("pulse_a_high", 33, ha);
    chk("pulse_b_high", 16, hb);
    apb(1'b0, ADDR_FLAG, 32'h0000_0000);
    chk("pulse_flags", 32'h0000_0003, rd);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk("pulse_run", 32'h0000_0000, rd);
  endtask : pulse_test

  // main sequence
  initial
  begin
    {rst_b, psel, pen, pwr, fire} = 5'b0;
    addr = 8'h00;
    wd = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    reg_test();
    pwm_test();
    cap_test();
    centre_test();
    pulse_test();
    summarize();
  end
endmodule : etp_top_tb_top

`default_nettype wire
